// ---- rtl/gate_timebase_pkg.sv ----
package gate_timebase_pkg;

  // ----------------------------------------------------------------
  // wishbone register map
  // ----------------------------------------------------------------
  localparam logic [3:0]  ADDR_IRQ_STATUS   = 4'h0;
  localparam logic [3:0]  ADDR_IRQ_MASK     = 4'h4;
  localparam logic [3:0]  ADDR_RUNDOWN_SET  = 4'h8;
  localparam logic [3:0]  ADDR_STATE        = 4'hc;
  localparam logic [15:0] RUNDOWN_SET_RESET = 16'h03e8;
  localparam logic [15:0] RUNDOWN_INFINITE  = 16'hffff;
  localparam int          IRQ_GATE_DONE_BIT = 0;
  localparam int          IRQ_RUNDOWN_BIT   = 1;

  // ----------------------------------------------------------------
  // control latch and status bus fields
  // ----------------------------------------------------------------
  localparam int CTL_GATE_EN_BIT  = 0;
  localparam int CTL_CNT_SEL_BIT  = 1;
  localparam int CTL_SEQ_EN_BIT   = 2;
  localparam int CTL_RES_LSB      = 3;
  localparam int CTL_RUNDOWN_BIT  = 3;
  localparam int STS_GATE_BUSY    = 0;
  localparam int STS_RUNDOWN      = 1;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          REF_HZ       = 10_000_000;
  localparam int          TICK1M_HZ    = 1_000_000;
  localparam int          TICK100K_HZ  = 100_000;
  localparam logic [3:0]  DIV_1M       = 4'((REF_HZ / TICK1M_HZ) - 1);
  localparam logic [3:0]  DIV_100K     = 4'((TICK1M_HZ / TICK100K_HZ) - 1);
  localparam logic [16:0] DEC_1HZ      = 17'd99999;
  localparam logic [16:0] DEC_10HZ     = 17'd9999;
  localparam logic [16:0] DEC_100HZ    = 17'd999;
  localparam logic [16:0] DEC_1KHZ     = 17'd99;
  localparam logic [16:0] DEC_10KHZ    = 17'd9;
  localparam logic [16:0] DEC_100KHZ   = 17'd0;

  typedef enum logic [1:0] {G_IDLE, G_ARM, G_OPEN} gate_state_t;

  typedef struct packed {
    logic       gate_en;
    logic       cnt_sel;
    logic       seq_en;
    logic [2:0] res;
  } ctl_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [3:0]  adr;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    ctl_t        ctl;
    logic        wr_strobe_n;
    logic        int_ref;
    logic        ext_ref;
    logic [3:0]  div1m;
    logic [3:0]  div100k;
    logic        ref_1m;
    logic        ref_500k;
    logic [16:0] decade;
    gate_state_t gstate;
    logic        gate_raw;
    logic        gate_mw;
    logic        gate_direct;
    logic        gate_busy;
    logic        rd_active;
    logic        rd_charging;
    logic [15:0] rd_count;
    logic [15:0] rd_setting;
    logic [1:0]  irq_status;
    logic [1:0]  irq_mask;
    logic        ack;
    logic [31:0] rdata;
    logic [5:0]  bus_out;
  } state_t;

endpackage

// ---- rtl/gate_timebase.sv ----
`timescale 1ns/100ps
module gate_timebase (
  input  wire logic                       CLK,
  input  wire logic                       NRST,
  input  wire gate_timebase_pkg::wb_req_t WB_REQ,
  output logic                            WB_ACK,
  output logic [31:0]                     WB_DAT_O,
  input  wire logic                       TIMING_WRITE_STROBE_N,
  input  wire logic                       TIMING_READ_STROBE_N,
  input  wire logic [5:0]                 DATA_IN,
  output logic [5:0]                      DATA_OUT,
  output logic                            DATA_OE,
  input  wire logic                       EXTERNAL_REF_SELECT_N,
  input  wire logic                       INT_REF_10M,
  input  wire logic                       EXT_REF_10M,
  output logic                            REF_1M,
  output logic                            REF_500K,
  output logic                            COUNTER_SEL,
  output logic                            GATE_MW,
  output logic                            GATE_DIRECT,
  output logic                            IRQ
);
  import gate_timebase_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [16:0] decade_last(input logic [2:0] code);
    unique case (code)
      3'b101:  decade_last = DEC_1HZ;
      3'b001:  decade_last = DEC_10HZ;
      3'b011:  decade_last = DEC_100HZ;
      3'b010:  decade_last = DEC_1KHZ;
      3'b100:  decade_last = DEC_10KHZ;
      default: decade_last = DEC_100KHZ;
    endcase
  endfunction

  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] wdat,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = wdat[i*8 +: 8];
      end
    end
    lane_merge = r;
  endfunction

  state_t s_ff;
  state_t nxt_s;

  logic        ref_sel;
  logic        ref_rise;
  logic        tick_1m;
  logic        tick_100k;
  logic        tick_div;
  logic        ctl_load;
  ctl_t        new_ctl;
  logic        gate_start;
  logic        gate_done_ev;
  logic        rd_done_ev;
  logic        wb_hit;
  logic [31:0] wb_old;
  logic [31:0] wb_merged;

  // ----------------------------------------------------------------
  // reference selection and dividers
  // ----------------------------------------------------------------
  always_comb begin
    ref_sel = EXTERNAL_REF_SELECT_N ? INT_REF_10M : EXT_REF_10M;
    // each source keeps its own history, so a change of selection makes no false edge
    ref_rise = ref_sel & ~(EXTERNAL_REF_SELECT_N ? s_ff.int_ref : s_ff.ext_ref);
    tick_1m = ref_rise && (s_ff.div1m == DIV_1M);
    tick_100k = tick_1m && (s_ff.div100k == DIV_100K);
    tick_div = tick_100k && (s_ff.decade == decade_last(s_ff.ctl.res));
  end

  // ----------------------------------------------------------------
  // strobed latch port
  // ----------------------------------------------------------------
  always_comb begin
    ctl_load = TIMING_WRITE_STROBE_N & ~s_ff.wr_strobe_n;
    new_ctl = '{gate_en: DATA_IN[CTL_GATE_EN_BIT],
                cnt_sel: DATA_IN[CTL_CNT_SEL_BIT],
                seq_en:  DATA_IN[CTL_SEQ_EN_BIT],
                res:     DATA_IN[CTL_RES_LSB +: 3]};
    gate_start = ctl_load && new_ctl.gate_en && new_ctl.cnt_sel && !new_ctl.seq_en;
    wb_hit = WB_REQ.cyc && WB_REQ.stb && !s_ff.ack;
  end

  always_comb begin
    unique case (WB_REQ.adr)
      ADDR_IRQ_STATUS:  wb_old = {30'h0, s_ff.irq_status};
      ADDR_IRQ_MASK:    wb_old = {30'h0, s_ff.irq_mask};
      ADDR_RUNDOWN_SET: wb_old = {16'h0, s_ff.rd_setting};
      ADDR_STATE:       wb_old = {22'h0, s_ff.gstate, s_ff.rd_active, s_ff.gate_busy,
                                  s_ff.ctl.res, s_ff.ctl.seq_en, s_ff.ctl.cnt_sel,
                                  s_ff.ctl.gate_en};
      default:          wb_old = 32'h0;
    endcase
    wb_merged = lane_merge(wb_old, WB_REQ.dat, WB_REQ.sel);
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    gate_done_ev = 1'b0;
    rd_done_ev = 1'b0;
    nxt_s.wr_strobe_n = TIMING_WRITE_STROBE_N;
    nxt_s.int_ref = INT_REF_10M;
    nxt_s.ext_ref = EXT_REF_10M;

    if (ref_rise) begin
      nxt_s.div1m = tick_1m ? 4'h0 : s_ff.div1m + 4'h1;
    end
    nxt_s.ref_1m = (nxt_s.div1m < 4'h5);
    if (tick_1m) begin
      nxt_s.ref_500k = ~s_ff.ref_500k;
      nxt_s.div100k = (s_ff.div100k == DIV_100K) ? 4'h0 : s_ff.div100k + 4'h1;
    end
    if (tick_100k) begin
      nxt_s.decade = tick_div ? 17'h0 : s_ff.decade + 17'h1;
    end

    if (ctl_load) begin
      nxt_s.ctl = new_ctl;
      if (new_ctl.res != s_ff.ctl.res) begin
        nxt_s.decade = 17'h0;
      end
    end

    // gate sequencer
    unique case (s_ff.gstate)
      G_IDLE: begin
        if (gate_start) begin
          nxt_s.gstate = G_ARM;
          nxt_s.gate_busy = 1'b1;
        end
      end
      G_ARM: begin
        if (ctl_load && !gate_start) begin
          nxt_s.gstate = G_IDLE;
          nxt_s.gate_busy = 1'b0;
        end else if (tick_div && !s_ff.ctl.seq_en) begin
          nxt_s.gstate = G_OPEN;
          nxt_s.gate_raw = 1'b1;
        end
      end
      G_OPEN: begin
        if (ctl_load && !gate_start) begin
          nxt_s.gstate = G_IDLE;
          nxt_s.gate_raw = 1'b0;
          nxt_s.gate_busy = 1'b0;
        end else if (tick_div) begin
          nxt_s.gstate = G_IDLE;
          nxt_s.gate_raw = 1'b0;
          nxt_s.gate_busy = 1'b0;
          gate_done_ev = 1'b1;
        end
      end
      default: begin
        nxt_s.gstate = G_IDLE;
        nxt_s.gate_raw = 1'b0;
        nxt_s.gate_busy = 1'b0;
      end
    endcase
    nxt_s.gate_mw = s_ff.gate_raw;
    nxt_s.gate_direct = s_ff.gate_raw;

    // rundown delay
    if (ctl_load && !new_ctl.res[0]) begin
      nxt_s.rd_charging = 1'b1;
      nxt_s.rd_active = 1'b1;
      nxt_s.rd_count = s_ff.rd_setting;
    end else if (s_ff.rd_charging) begin
      if (ctl_load && new_ctl.res[0]) begin
        nxt_s.rd_charging = 1'b0;
      end
      nxt_s.rd_count = s_ff.rd_setting;
    end else if (s_ff.rd_active && s_ff.rd_count != RUNDOWN_INFINITE) begin
      if (s_ff.rd_count == 16'h0) begin
        nxt_s.rd_active = 1'b0;
        rd_done_ev = 1'b1;
      end else if (tick_1m) begin
        nxt_s.rd_count = s_ff.rd_count - 16'h1;
      end
    end

    // wishbone slave
    nxt_s.ack = wb_hit;
    nxt_s.rdata = 32'h0;
    if (wb_hit) begin
      nxt_s.rdata = wb_old;
      if (WB_REQ.we) begin
        unique case (WB_REQ.adr)
          ADDR_IRQ_STATUS:  nxt_s.irq_status = s_ff.irq_status & ~wb_merged[1:0];
          ADDR_IRQ_MASK:    nxt_s.irq_mask = wb_merged[1:0];
          ADDR_RUNDOWN_SET: nxt_s.rd_setting = wb_merged[15:0];
          default: begin
          end
        endcase
      end
    end
    // set wins over a simultaneous clear
    if (gate_done_ev) begin
      nxt_s.irq_status[IRQ_GATE_DONE_BIT] = 1'b1;
    end
    if (rd_done_ev) begin
      nxt_s.irq_status[IRQ_RUNDOWN_BIT] = 1'b1;
    end

    // read-back through the strobed port, reserved lines at zero
    nxt_s.bus_out = 6'h0;
    nxt_s.bus_out[STS_GATE_BUSY] = nxt_s.gate_busy;
    nxt_s.bus_out[STS_RUNDOWN] = nxt_s.rd_active;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      s_ff <= '{ctl: '{gate_en: 1'b0, cnt_sel: 1'b0, seq_en: 1'b0, res: 3'h0},
                wr_strobe_n: 1'b1,
                int_ref: 1'b0,
                ext_ref: 1'b0,
                div1m: 4'h0,
                div100k: 4'h0,
                ref_1m: 1'b0,
                ref_500k: 1'b0,
                decade: 17'h0,
                gstate: G_IDLE,
                gate_raw: 1'b0,
                gate_mw: 1'b0,
                gate_direct: 1'b0,
                gate_busy: 1'b0,
                rd_active: 1'b0,
                rd_charging: 1'b0,
                rd_count: 16'h0,
                rd_setting: RUNDOWN_SET_RESET,
                irq_status: 2'h0,
                irq_mask: 2'h0,
                ack: 1'b0,
                rdata: 32'h0,
                bus_out: 6'h0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_comb begin
    WB_ACK = s_ff.ack;
    WB_DAT_O = s_ff.rdata;
    DATA_OUT = s_ff.bus_out;
    DATA_OE = ~TIMING_READ_STROBE_N;
    REF_1M = s_ff.ref_1m;
    REF_500K = s_ff.ref_500k;
    COUNTER_SEL = s_ff.ctl.cnt_sel;
    GATE_MW = s_ff.gate_mw;
    GATE_DIRECT = s_ff.gate_direct;
    IRQ = |(s_ff.irq_status & s_ff.irq_mask);
  end

endmodule

// ---- verification/gate_timebase_props.sv ----
`timescale 1ns/100ps
module gate_timebase_props (
  input wire logic                       CLK,
  input wire logic                       NRST,
  input wire gate_timebase_pkg::wb_req_t WB_REQ,
  input wire logic                       WB_ACK,
  input wire logic [31:0]                WB_DAT_O,
  input wire logic                       TIMING_WRITE_STROBE_N,
  input wire logic                       TIMING_READ_STROBE_N,
  input wire logic [5:0]                 DATA_OUT,
  input wire logic                       DATA_OE,
  input wire logic                       REF_1M,
  input wire logic                       REF_500K,
  input wire logic                       GATE_MW,
  input wire logic                       GATE_DIRECT
);
  import gate_timebase_pkg::*;
  logic [15:0] gate_len_ff;
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  // counts cycles the gate has been open
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      gate_len_ff <= 16'h0000;
    end else begin
      gate_len_ff <= GATE_MW ? gate_len_ff + 16'h0001 : 16'h0000;
    end
  end
  property p_oe; DATA_OE == !TIMING_READ_STROBE_N; endproperty
  property p_ack; WB_REQ.cyc && WB_REQ.stb && !WB_ACK |=> WB_ACK ##1 !WB_ACK; endproperty
  property p_dat; !WB_ACK |-> WB_DAT_O == 32'h0; endproperty
  property p_rsv; DATA_OUT[5:2] == 4'h0; endproperty
  property p_pair; GATE_MW == GATE_DIRECT; endproperty
  property p_len; $fell(GATE_MW) |-> gate_len_ff >= 16'h04d8; endproperty
  property p_done; $fell(GATE_MW) |-> ##[0:2] !DATA_OUT[STS_GATE_BUSY]; endproperty
  property p_1m; $rose(REF_1M) |=> REF_1M [*8]; endproperty
  property p_500k; $changed(REF_500K) |=> $stable(REF_500K) [*8]; endproperty
  property p_rd;
    $rose(DATA_OUT[STS_RUNDOWN]) |->
      ($past(TIMING_WRITE_STROBE_N) && !$past(TIMING_WRITE_STROBE_N, 2)) ||
      ($past(TIMING_WRITE_STROBE_N, 2) && !$past(TIMING_WRITE_STROBE_N, 3));
  endproperty
  a_oe: assert property (p_oe) else $error("status driver enable wrong");
  a_ack: assert property (p_ack) else $error("bus ack not one cycle");
  a_dat: assert property (p_dat) else $error("read data outside ack");
  a_rsv: assert property (p_rsv) else $error("spare status lines not zero");
  a_pair: assert property (p_pair) else $error("gate flops disagree");
  a_len: assert property (p_len) else $error("gate shorter than a period");
  a_done: assert property (p_done) else $error("done not shown after gate");
  a_1m: assert property (p_1m) else $error("1 MHz high phase short");
  a_500k: assert property (p_500k) else $error("500 kHz toggles too fast");
  a_rd: assert property (p_rd) else $error("rundown set without write");
  c_gate: cover property ($fell(GATE_MW));
  c_rd: cover property ($fell(DATA_OUT[STS_RUNDOWN]));
  c_wb: cover property (WB_ACK);
endmodule
bind gate_timebase gate_timebase_props i_props (
  .CLK(CLK), .NRST(NRST), .WB_REQ(WB_REQ), .WB_ACK(WB_ACK), .WB_DAT_O(WB_DAT_O),
  .TIMING_WRITE_STROBE_N(TIMING_WRITE_STROBE_N), .TIMING_READ_STROBE_N(TIMING_READ_STROBE_N),
  .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE), .REF_1M(REF_1M), .REF_500K(REF_500K),
  .GATE_MW(GATE_MW), .GATE_DIRECT(GATE_DIRECT));

// ---- verification/host_model.sv ----
`timescale 1ns/100ps
module host_model (
  input  wire logic       clk,
  output logic            wr_n,
  output logic            rd_n,
  output logic [5:0]      data,
  input  wire logic [5:0] status,
  input  wire logic       status_oe
);
  initial begin
    wr_n = 1'b1;
    rd_n = 1'b1;
    data = 6'h2a;
  end
  task automatic write_latch(input logic [5:0] d);
    @(posedge clk);
    data <= d;
    wr_n <= 1'b0;
    repeat (2) @(posedge clk);
    wr_n <= 1'b1;
    @(posedge clk);
    data <= ~d;
  endtask
  task automatic read_status(output logic [5:0] s, output logic oe);
    @(posedge clk);
    rd_n <= 1'b0;
    repeat (2) @(posedge clk);
    s = status;
    oe = status_oe;
    rd_n <= 1'b1;
  endtask
  task automatic start_gate(input logic [2:0] code);
    write_latch({code, 1'b0, 1'b1, 1'b1});
  endtask
  task automatic start_rundown();
    write_latch(6'h00);
    write_latch(6'h08);
  endtask
  task automatic wait_done();
    logic [5:0] s;
    logic       oe;
    do read_status(s, oe); while (s[0] !== 1'b0);
  endtask
endmodule

// ---- verification/testbench.sv ----
`timescale 1ns/100ps
module testbench;
  import gate_timebase_pkg::*;
  wb_req_t     wb_req;
  logic [31:0] wb_dat, rdat;
  logic [5:0]  din, dout, st;
  logic        clk = 1'b0, int_ref = 1'b0, ext_ref = 1'b0;
  logic        nrst, ext_sel_n, ext_run, wb_ack, oe, data_oe;
  logic        ref_1m, ref_500k, cnt_sel, gate_mw, gate_direct, irq, wr_n, rd_n;
  int          fails = 0, comparisons = 0, cycles = 0;
  always #4 clk = ~clk;
  // references from a phase counter: 25 clk cycles hold two 10 MHz periods
  int          ref_ph = 0;
  always @(posedge clk) begin
    ref_ph <= (ref_ph == 24) ? 0 : ref_ph + 1;
    if (ref_ph % 6 == 0 && ref_ph != 24) begin
      int_ref <= ~int_ref;
      if (ext_run) begin
        ext_ref <= ~ext_ref;
      end
    end
  end
  gate_timebase i_dut (.CLK(clk), .NRST(nrst), .WB_REQ(wb_req), .WB_ACK(wb_ack),
    .WB_DAT_O(wb_dat), .TIMING_WRITE_STROBE_N(wr_n), .TIMING_READ_STROBE_N(rd_n),
    .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(data_oe), .EXTERNAL_REF_SELECT_N(ext_sel_n),
    .INT_REF_10M(int_ref), .EXT_REF_10M(ext_ref), .REF_1M(ref_1m), .REF_500K(ref_500k),
    .COUNTER_SEL(cnt_sel), .GATE_MW(gate_mw), .GATE_DIRECT(gate_direct), .IRQ(irq));
  host_model i_host (.clk(clk), .wr_n(wr_n), .rd_n(rd_n), .data(din), .status(dout),
    .status_oe(data_oe));
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      fails++;
      report_and_stop();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d);
    wb_req <= '{1'b1, 1'b1, we, 4'hf, adr, d};
    @(posedge clk);
    while (wb_ack !== 1'b1) @(posedge clk);
    rdat = wb_dat;
    wb_req <= '0;
    @(posedge clk);
  endtask
  task automatic t_regs();
    wb(1'b0, ADDR_RUNDOWN_SET, 32'h0);
    check("rundown setting reset", rdat, {16'h0, RUNDOWN_SET_RESET});
    wb(1'b0, ADDR_IRQ_MASK, 32'h0);
    check("mask reset", rdat, 32'h0);
    wb(1'b1, 4'h2, 32'hffff_ffff);
    wb(1'b0, 4'h2, 32'h0);
    check("unmapped read", rdat, 32'h0);
    wb(1'b1, ADDR_STATE, 32'h3f);
    wb(1'b0, ADDR_STATE, 32'h0);
    check("state read only", rdat, 32'h0);
  endtask
  task automatic count_ref(output int r1, output int r5);
    logic p1, p5;
    r1 = 0;
    r5 = 0;
    p1 = ref_1m;
    p5 = ref_500k;
    repeat (1250) begin
      @(posedge clk);
      r1 += int'(ref_1m && !p1);
      r5 += int'(ref_500k && !p5);
      p1 = ref_1m;
      p5 = ref_500k;
    end
  endtask
  task automatic t_ref();
    int r1, r5;
    count_ref(r1, r5);
    check("1 MHz rises", 32'(r1 inside {[9:11]}), 32'h1);
    check("500 kHz rises", 32'(r5 inside {[4:6]}), 32'h1);
    ext_sel_n <= 1'b0;
    count_ref(r1, r5);
    check("external stopped", 32'(r1 < 2), 32'h1);
    ext_run <= 1'b1;
    count_ref(r1, r5);
    check("external running", 32'(r1 inside {[9:11]}), 32'h1);
    ext_sel_n <= 1'b1;
  endtask
  task automatic t_gate(input logic [2:0] code, input int len, input logic m);
    int hi;
    wb(1'b1, ADDR_IRQ_MASK, {31'h0, m});
    i_host.start_gate(code);
    i_host.read_status(st, oe);
    check("status while gating", 32'({st, oe}), 32'h7);
    while (!gate_mw) @(posedge clk);
    check("direct gate open", 32'(gate_direct), 32'h1);
    hi = 0;
    while (gate_mw) begin
      @(posedge clk);
      hi++;
    end
    check("direct gate closed", 32'(gate_direct), 32'h0);
    check("gate length", 32'(hi inside {[len - 15:len + 15]}), 32'h1);
    i_host.wait_done();
    check("counter select", 32'(cnt_sel), 32'h1);
    check("done irq", 32'(irq), 32'(m));
    wb(1'b0, ADDR_IRQ_STATUS, 32'h0);
    check("done status", rdat, 32'h1);
    wb(1'b1, ADDR_IRQ_STATUS, 32'h1);
    wb(1'b0, ADDR_IRQ_STATUS, 32'h0);
    check("status cleared", rdat | 32'(irq), 32'h0);
  endtask
  task automatic t_abort();
    int hi;
    i_host.start_gate(3'b000);
    i_host.write_latch(6'h00);
    i_host.read_status(st, oe);
    check("abort busy", 32'(st[STS_GATE_BUSY]), 32'h0);
    hi = 0;
    repeat (2600) begin
      @(posedge clk);
      hi += int'(gate_mw);
    end
    check("abort gate", 32'(hi), 32'h0);
    wb(1'b0, ADDR_IRQ_STATUS, 32'h0);
    check("abort no done", rdat, 32'h0);
  endtask
  task automatic t_rundown();
    int t;
    wb(1'b1, ADDR_RUNDOWN_SET, 32'h5);
    wb(1'b1, ADDR_IRQ_MASK, 32'h2);
    // start just after a 1 MHz tick so the count phase is known
    while (ref_1m) @(posedge clk);
    while (!ref_1m) @(posedge clk);
    i_host.start_rundown();
    t = 0;
    while (dout[STS_RUNDOWN]) begin
      @(posedge clk);
      t++;
    end
    check("rundown delay", 32'(t inside {[560:660]}), 32'h1);
    check("expiry irq", 32'(irq), 32'h1);
    wb(1'b1, ADDR_IRQ_STATUS, 32'h3);
    wb(1'b1, ADDR_RUNDOWN_SET, {16'h0, RUNDOWN_INFINITE});
    i_host.start_rundown();
    repeat (2500) @(posedge clk);
    check("rundown infinite", 32'({irq, dout[STS_RUNDOWN]}), 32'h1);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    nrst = 1'b0;
    wb_req = '0;
    ext_sel_n = 1'b1;
    ext_run = 1'b0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_regs();
    $display("test registers done");
    t_ref();
    $display("test references done");
    t_gate(3'b000, 1250, 1'b1);
    t_gate(3'b100, 12500, 1'b0);
    t_abort();
    $display("test gates done");
    t_rundown();
    $display("test rundown done");
    report_and_stop();
  end
endmodule
